// file: hw/sar_ctrl_cfg.svh
`ifndef SAR_CTRL_CFG_SVH
`define SAR_CTRL_CFG_SVH

// Result width and channel count
`define SAR_BITS 8
`define SAR_CHANNELS 8
`define SAR_SEL_BITS 3
// Clock periods per decided bit; 8 bits x 8 gives 64 per conversion
`define SAR_STEP_CYCLES 8
// Most clocks from start rise to end-of-conversion low
`define SAR_EOC_LOW_MAX 8
// Reset values
`define SAR_RESULT_RST 8'h00
`define SAR_CHAN_RST 3'h0
`define SAR_ONEHOT_RST 8'h01

`endif

// file: hw/sar_ctrl_pkg.sv
package sar_ctrl_pkg;
    // Sequencer states, Gray coded along idle -> armed -> trial -> done -> idle
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_ARMED = 2'b01,
        ST_TRIAL = 2'b11,
        ST_DONE = 2'b10
    } seq_state_e;

    // Bus-side control inputs that travel together
    typedef struct packed {
        logic latch_strobe;
        logic start;
        logic out_enable;
        logic [2:0] chan_sel;
    } host_ctrl_s;
endpackage

// file: hw/sar_adc_mux_control.sv
`timescale 1ns/10ps
`include "sar_ctrl_cfg.svh"

module sar_adc_mux_control #(
    parameter int BITS = `SAR_BITS,
    parameter int STEP_CYCLES = `SAR_STEP_CYCLES
) (
    // Clock and reset
    input wire logic I_CLK,
    input wire logic I_RST_N,
    // Host control, sampled synchronously
    input wire sar_ctrl_pkg::host_ctrl_s I_CTRL,
    // Comparator: high when selected input is at or above trial level
    input wire logic I_CMP_GE,
    // Analog side
    output logic [`SAR_CHANNELS-1:0] O_CHAN_ONEHOT,
    output logic [BITS-1:0] O_TRIAL_CODE,
    // Completion and data pins
    output logic O_EOC,
    output logic [BITS-1:0] O_DATA,
    output logic [BITS-1:0] O_DATA_OE_N
);

    localparam int CW = $clog2(STEP_CYCLES);
    localparam int BW = $clog2(BITS);

    sar_ctrl_pkg::seq_state_e state, next_state;
    logic [BITS-1:0] approx_register, next_approx_register;
    logic [BITS-1:0] result, next_result;
    logic [BW-1:0] bit_idx, next_bit_idx;
    logic [CW-1:0] step_cnt, next_step_cnt;
    logic [`SAR_SEL_BITS-1:0] chan, next_chan;
    logic [`SAR_CHANNELS-1:0] chan_onehot, next_chan_onehot;
    logic eoc, next_eoc;
    logic oe_n, next_oe_n;
    logic prev_ale, prev_start;
    logic start_rise, start_fall, ale_rise;

    // Edge detection on synchronous host inputs
    assign start_rise = I_CTRL.start & ~prev_start;
    assign start_fall = ~I_CTRL.start & prev_start;
    assign ale_rise = I_CTRL.latch_strobe & ~prev_ale;

    // Channel latch and decode
    always_comb begin
        next_chan = chan;
        if (ale_rise) begin
            next_chan = I_CTRL.chan_sel;
        end
        next_chan_onehot = '0;
        next_chan_onehot[next_chan] = 1'b1;
    end

    // Sequencer: start rise clears, start fall launches
    always_comb begin
        next_state = state;
        next_approx_register = approx_register;
        next_result = result;
        next_bit_idx = bit_idx;
        next_step_cnt = step_cnt;
        next_eoc = eoc;
        if (start_rise) begin
            // Abandon any conversion in progress
            next_state = sar_ctrl_pkg::ST_ARMED;
            next_approx_register = '0;
            next_eoc = 1'b0;
        end else if (start_fall && state == sar_ctrl_pkg::ST_ARMED) begin
            // Launch: set MSB as first trial
            next_state = sar_ctrl_pkg::ST_TRIAL;
            next_bit_idx = BW'(BITS - 1);
            next_approx_register = '0;
            next_approx_register[BITS-1] = 1'b1;
            next_step_cnt = '0;
        end else begin
            unique case (state)
                sar_ctrl_pkg::ST_IDLE, sar_ctrl_pkg::ST_ARMED: begin
                end
                sar_ctrl_pkg::ST_TRIAL: begin
                    next_step_cnt = CW'(step_cnt + 1'b1);
                    if (step_cnt == CW'(STEP_CYCLES - 1)) begin
                        // Comparator strobed at end of each bit slot
                        next_approx_register[bit_idx] = I_CMP_GE;
                        if (bit_idx == '0) begin
                            next_state = sar_ctrl_pkg::ST_DONE;
                        end else begin
                            next_bit_idx = BW'(bit_idx - 1'b1);
                            next_approx_register[bit_idx-1'b1] = 1'b1;
                        end
                    end
                end
                sar_ctrl_pkg::ST_DONE: begin
                    // Data loads this edge, flag rises next edge
                    next_result = approx_register;
                    next_state = sar_ctrl_pkg::ST_IDLE;
                end
            endcase
            if (state == sar_ctrl_pkg::ST_IDLE && !eoc) begin
                next_eoc = 1'b1;
            end
        end
        next_oe_n = ~I_CTRL.out_enable;
    end

    // State registers
    always_ff @(posedge I_CLK) begin
        if (!I_RST_N) begin
            state <= sar_ctrl_pkg::ST_IDLE;
            approx_register <= '0;
            result <= `SAR_RESULT_RST;
            bit_idx <= '0;
            step_cnt <= '0;
            eoc <= 1'b0;
            oe_n <= 1'b1;
            chan <= `SAR_CHAN_RST;
            chan_onehot <= `SAR_ONEHOT_RST;
            prev_ale <= 1'b0;
            prev_start <= 1'b0;
        end else begin
            state <= next_state;
            approx_register <= next_approx_register;
            result <= next_result;
            bit_idx <= next_bit_idx;
            step_cnt <= next_step_cnt;
            eoc <= next_eoc;
            oe_n <= next_oe_n;
            chan <= next_chan;
            chan_onehot <= next_chan_onehot;
            prev_ale <= I_CTRL.latch_strobe;
            prev_start <= I_CTRL.start;
        end
    end

    // Outputs straight from flops; data always presented, enable gates pins
    assign O_EOC = eoc;
    assign O_DATA = result;
    assign O_DATA_OE_N = {BITS{oe_n}};
    assign O_CHAN_ONEHOT = chan_onehot;
    assign O_TRIAL_CODE = approx_register;

    // Checks
    property p_chan_latch;
        @(posedge I_CLK) disable iff (!I_RST_N)
        ale_rise |=> O_CHAN_ONEHOT == (8'h01 << $past(I_CTRL.chan_sel));
    endproperty
    a_chan_latch: assert property (p_chan_latch) else $error("channel not latched");
    property p_chan_hold;
        @(posedge I_CLK) disable iff (!I_RST_N)
        !ale_rise |=> $stable(chan);
    endproperty
    a_chan_hold: assert property (p_chan_hold) else $error("channel changed");
    // Decode always matches the latched code
    property p_chan_decode;
        @(posedge I_CLK) disable iff (!I_RST_N)
        1 |-> O_CHAN_ONEHOT == (8'h01 << chan);
    endproperty
    a_chan_decode: assert property (p_chan_decode) else $error("channel decode wrong");
    property p_clear;
        @(posedge I_CLK) disable iff (!I_RST_N)
        start_rise |=> approx_register == '0;
    endproperty
    a_clear: assert property (p_clear) else $error("approx not cleared");
    property p_launch;
        @(posedge I_CLK) disable iff (!I_RST_N)
        start_fall && state == sar_ctrl_pkg::ST_ARMED |=>
            state == sar_ctrl_pkg::ST_TRIAL && approx_register == 8'h80;
    endproperty
    a_launch: assert property (p_launch) else $error("no launch on fall");
    property p_eoc_low;
        @(posedge I_CLK) disable iff (!I_RST_N)
        start_rise |-> ##[1:8] !O_EOC;
    endproperty
    a_eoc_low: assert property (p_eoc_low) else $error("eoc late low");
    // Result lands while the flag is still low; a restart in that cycle drops it
    property p_load_before_eoc;
        @(posedge I_CLK) disable iff (!I_RST_N)
        state == sar_ctrl_pkg::ST_DONE && !start_rise |=>
            O_DATA == $past(approx_register) && !O_EOC;
    endproperty
    a_load_before_eoc: assert property (p_load_before_eoc) else $error("eoc order");
    // Comparator decides the bit under trial at the end of its slot
    property p_decide;
        @(posedge I_CLK) disable iff (!I_RST_N)
        state == sar_ctrl_pkg::ST_TRIAL && step_cnt == CW'(STEP_CYCLES - 1) && !start_rise |=>
            approx_register[$past(bit_idx)] == $past(I_CMP_GE);
    endproperty
    a_decide: assert property (p_decide) else $error("bit decision wrong");
    property p_total;
        @(posedge I_CLK) disable iff (!I_RST_N || start_rise)
        $rose(state == sar_ctrl_pkg::ST_TRIAL) |-> ##64 state == sar_ctrl_pkg::ST_DONE ##2 O_EOC;
    endproperty
    a_total: assert property (p_total) else $error("conversion length wrong");
    property p_eoc_during;
        @(posedge I_CLK) disable iff (!I_RST_N)
        state == sar_ctrl_pkg::ST_TRIAL |-> !O_EOC && $stable(O_DATA);
    endproperty
    a_eoc_during: assert property (p_eoc_during) else $error("eoc or data moved");
    property p_oe;
        @(posedge I_CLK) disable iff (!I_RST_N)
        1 |=> O_DATA_OE_N == {BITS{!$past(I_CTRL.out_enable)}};
    endproperty
    a_oe: assert property (p_oe) else $error("output enable wrong");

    c_full: cover property (p_total);
    c_restart: cover property (@(posedge I_CLK) state == sar_ctrl_pkg::ST_TRIAL && start_rise);
    c_read: cover property (@(posedge I_CLK) O_EOC && !O_DATA_OE_N[0]);
    c_chan7: cover property (@(posedge I_CLK) O_CHAN_ONEHOT[7]);

endmodule

// file: verif/sar_analog_partner.sv
`timescale 1ns/10ps
// Analog side stand-in: mux, ladder, comparator and the free-run strap
module sar_analog_partner (
    // Converter outputs
    input wire logic [7:0] i_chan_onehot,
    input wire logic [7:0] i_trial_code,
    input wire logic i_eoc,
    // Input levels, one byte per channel
    input wire logic [63:0] i_levels,
    // Comparator and strap
    output logic o_cmp_ge,
    output logic o_start_fb
);
    logic [7:0] level;
    // Selected level; an empty select compares zero, so it cannot hide
    always_comb begin
        level = 8'h00;
        for (int n = 7; n >= 0; n--) begin
            if (i_chan_onehot[n]) begin
                level = i_levels[n*8 +: 8];
            end
        end
    end
    // Combinational like the real comparator; no settling is modelled
    assign o_cmp_ge = (level >= i_trial_code);
    assign o_start_fb = i_eoc;
endmodule

// file: verif/sar_adc_mux_control_tb.sv
`timescale 1ns/10ps
module sar_adc_mux_control_tb;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic free_run = 1'b0;
    sar_ctrl_pkg::host_ctrl_s ctrl = '0;
    sar_ctrl_pkg::host_ctrl_s ctrl_in;
    logic cmp_ge, start_fb, eoc;
    logic [7:0] onehot, trial, data, oe_n, lvl, last, d1, d2;
    logic [63:0] levels = 64'h0;
    wire [7:0] pins;
    int err_total = 0;
    int total_checks = 0;
    int exp_q[$];
    int n, cut;

    always #20 clk = ~clk;
    // Strap replaces the bench start only in free-running mode
    always_comb begin
        ctrl_in = ctrl;
        if (free_run) ctrl_in.start = start_fb;
    end
    // Pin level resolved from data and active-low enable
    for (genvar g = 0; g < 8; g++) begin : g_pin
        assign pins[g] = oe_n[g] ? 1'bz : data[g];
    end

    sar_adc_mux_control #(.BITS(8), .STEP_CYCLES(8)) u_dut (.I_CLK(clk), .I_RST_N(rst_n),
        .I_CTRL(ctrl_in), .I_CMP_GE(cmp_ge), .O_CHAN_ONEHOT(onehot), .O_TRIAL_CODE(trial),
        .O_EOC(eoc), .O_DATA(data), .O_DATA_OE_N(oe_n));
    sar_analog_partner u_far (.i_chan_onehot(onehot), .i_trial_code(trial), .i_eoc(eoc),
        .i_levels(levels), .o_cmp_ge(cmp_ge), .o_start_fb(start_fb));

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic end_sim();
        if (err_total == 0 && total_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    // Latch a channel, convert a random level, optionally restart at cycle cut
    task automatic convert(input logic [2:0] ch, input int cut_at);
        @(posedge clk);
        cut = cut_at;
        lvl = 8'($urandom);
        exp_q.push_back(int'(lvl));
        levels[int'(ch)*8 +: 8] <= lvl;
        ctrl.chan_sel <= ch;
        ctrl.latch_strobe <= 1'b1;
        @(posedge clk);
        ctrl.latch_strobe <= 1'b0;
        ctrl.chan_sel <= ~ch;
        @(posedge clk);
        ctrl.start <= 1'b1;
        #1 check(onehot, 8'h01 << ch);
        @(posedge clk);
        ctrl.start <= 1'b0;
        n = -1;
        while (n < 200) begin
            @(posedge clk);
            if (n == cut) ctrl.start <= 1'b1;
            if (n == cut + 1) begin
                ctrl.start <= 1'b0;
                lvl = 8'($urandom);
                void'(exp_q.pop_back());
                exp_q.push_back(int'(lvl));
                levels[int'(ch)*8 +: 8] <= lvl;
            end
            if (n == cut + 2) begin
                n = 0;
                cut = 999;
            end else n++;
            #1;
            if (n == 0) check({7'h00, eoc}, 8'h00);
            if (n == 1) check(trial, 8'h80);
            if (eoc === 1'b1) break;
            d2 = d1;
            d1 = data;
        end
        lvl = 8'(exp_q.pop_front());
        // Launch edge is n=0: 64 bit cycles, one load edge, one flag edge
        check(8'(n), 8'h42);
        check(data, lvl);
        check(d1, lvl);
        check(d2, last);
        last = lvl;
        // Pins follow the enable one cycle late; driven value checked just after the enable drops
        @(posedge clk);
        ctrl.out_enable <= 1'b1;
        repeat (2) @(posedge clk);
        ctrl.out_enable <= 1'b0;
        #1 check(pins, lvl);
        repeat (2) @(posedge clk);
        #1 check(pins, 8'hzz);
    endtask

    // Main sequence: reset values, every channel, a restart, free running
    initial begin
        void'($urandom(69));
        last = 8'h00;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        #1 check({onehot[3:0], data[3:0]}, 8'h10);
        check({oe_n[6:0], eoc}, 8'hfe);
        repeat (2) @(posedge clk);
        #1 check({7'h00, eoc}, 8'h01);
        for (int c = 0; c < 8; c++) convert(3'(c), 999);
        convert(3'h5, 20);
        // Loop is primed by the end-of-conversion flag left high by the runs above
        @(posedge clk);
        free_run <= 1'b1;
        repeat (2) begin
            n = 0;
            lvl = 8'($urandom);
            // Fresh level lands at the edge that sees the strap's start rise
            while (eoc === 1'b1 && n < 20) begin
                @(posedge clk);
                levels[47:40] <= lvl;
                #1 n++;
            end
            while (eoc !== 1'b1 && n < 200) begin
                @(posedge clk);
                #1 n++;
            end
            check(data, lvl);
            // Rise edge, launch edge, 64 bit cycles, load and flag edges
            check(8'(n), 8'h44);
        end
        end_sim();
    end

    // Eleven conversions of about 80 cycles each; 5000 cycles is ample
    initial begin
        #200000;
        err_total++;
        end_sim();
    end
endmodule
